// *** tcc_sync.sv ***
// Shared constants for the configuration-channel status block, plus its input synchroniser
`timescale 1ns/100ps
`default_nettype none

package tcc_pkg;
  localparam logic [6:0] TCC_ADDR_STRAP_HIGH = 7'h67;
  localparam logic [6:0] TCC_ADDR_STRAP_LOW = 7'h47;
  localparam logic [6:0] TCC_ADDR_NONE = 7'h00;
  localparam int TCC_CLK_MHZ = 50;
  localparam int TCC_TOGGLE_HALF_US = 50;
  localparam int TCC_TOGGLE_CYCLES = TCC_TOGGLE_HALF_US * TCC_CLK_MHZ;
  localparam int TCC_TOGGLE_W = $clog2(TCC_TOGGLE_CYCLES + 1);
  localparam logic [1:0] TCC_LVL_NONE = 2'h0;
  localparam logic [1:0] TCC_LVL_DEFAULT = 2'h1;
  localparam logic [1:0] TCC_LVL_MEDIUM = 2'h2;
  localparam logic [1:0] TCC_LVL_HIGH = 2'h3;
  localparam int TCC_SYNC_W = 14;
  localparam logic [TCC_SYNC_W-1:0] TCC_SYNC_RESET = 14'h0001;
  typedef enum logic [1:0] {TCC_ROLE_SOURCE, TCC_ROLE_SINK, TCC_ROLE_DUAL} tcc_role_t;
  typedef enum logic [1:0] {TCC_MODE_NONE, TCC_MODE_BUS_HIGH, TCC_MODE_BUS_LOW, TCC_MODE_GPIO} tcc_mode_t;
  typedef enum logic [2:0] {TCC_ST_OFF, TCC_ST_UNATT_SRC, TCC_ST_UNATT_SNK, TCC_ST_ATT_SRC,
                            TCC_ST_ATT_SNK, TCC_ST_AUDIO} tcc_state_t;
  // Stronger of two advertised levels; only one CC line should carry one
  function automatic logic [1:0] maxLevel(input logic [1:0] a, input logic [1:0] b);
    maxLevel = (a > b) ? a : b;
  endfunction
endpackage

module tcc_sync
  import tcc_pkg::*;
#(
  parameter int WIDTH = TCC_SYNC_W,
  parameter logic [WIDTH-1:0] RESET_VALUE = TCC_SYNC_RESET
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] nxt_stage1;
  logic [WIDTH-1:0] nxt_stage2;

  always_comb
  begin
    nxt_stage1 = asyncIn;
    nxt_stage2 = stage1_ff;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1_ff <= RESET_VALUE;
      stage2_ff <= RESET_VALUE;
    end
    else
    begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign syncOut = stage2_ff;
endmodule

`default_nettype wire

// *** tcc_cc_status.sv ***
// Configuration-channel attach detection with strap decode and open-drain status pins
`timescale 1ns/100ps
`default_nettype none

module tcc_cc_status
  import tcc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enableN,
  input wire logic strapHigh,
  input wire logic strapLow,
  input wire logic busPowerSense,
  input wire logic [1:0] ccRdDet,
  input wire logic [1:0] ccRaDet,
  input wire logic [1:0] cc1RpLevel,
  input wire logic [1:0] cc2RpLevel,
  input wire logic [1:0] roleSelect,
  input wire logic regChange,
  input wire logic intClear,
  input wire logic sdaIn,
  input wire logic sclIn,
  input wire logic busSdaPullLow,
  input wire logic busSclHold,
  output logic orientOut,
  output logic orientOeN,
  output logic sourceAttachOut,
  output logic sourceAttachOeN,
  output logic sharedIntOut,
  output logic sharedIntOeN,
  output logic sdaOut,
  output logic sdaOeN,
  output logic sclOut,
  output logic sclOeN,
  output logic busEnable,
  output logic [6:0] busAddress,
  output logic busSdaIn,
  output logic busSclIn,
  output logic attached,
  output logic [1:0] currentLevel
);
  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  logic enSyncN, en, sHigh, sLow, vbus, sdaSync, sclSync;
  logic [1:0] rd, ra, rp1, rp2;

  tcc_sync #(.WIDTH(TCC_SYNC_W), .RESET_VALUE(TCC_SYNC_RESET)) uSync (
    .clk(clk),
    .reset_n(reset_n),
    .asyncIn({sclIn, sdaIn, cc2RpLevel, cc1RpLevel, ccRaDet, ccRdDet, busPowerSense, strapLow, strapHigh, enableN}),
    .syncOut({sclSync, sdaSync, rp2, rp1, ra, rd, vbus, sLow, sHigh, enSyncN})
  );
  assign en = ~enSyncN;

  // ---------------------------------------------------------------
  // Strap capture and attach state machine
  // ---------------------------------------------------------------
  tcc_mode_t mode_ff, nxt_mode;
  tcc_state_t state_ff, nxt_state;
  tcc_role_t role;
  logic [TCC_TOGGLE_W-1:0] toggleCnt_ff, nxt_toggleCnt;
  logic [1:0] level_ff, nxt_level;
  logic orientPos2_ff, nxt_orientPos2, intPend_ff, nxt_intPend, busMode;
  // Standalone strap forces dual-role; fixed roles need the register bus to pick them
  assign busMode = (mode_ff == TCC_MODE_BUS_HIGH) || (mode_ff == TCC_MODE_BUS_LOW);
  assign role = (busMode && roleSelect != 2'(TCC_ROLE_DUAL) && roleSelect <= 2'(TCC_ROLE_SINK)) ?
                tcc_role_t'(roleSelect) : TCC_ROLE_DUAL;

  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_state = state_ff;
    nxt_orientPos2 = orientPos2_ff;
    nxt_level = level_ff;
    nxt_toggleCnt = (toggleCnt_ff == '0) ? TCC_TOGGLE_W'(TCC_TOGGLE_CYCLES) : toggleCnt_ff - 1'b1;
    // Strap is caught once per enable so a pin glitch later cannot move the bus address
    if (!en)
      nxt_mode = TCC_MODE_NONE;
    else if (mode_ff == TCC_MODE_NONE)
      nxt_mode = sHigh ? TCC_MODE_BUS_HIGH : (sLow ? TCC_MODE_BUS_LOW : TCC_MODE_GPIO);
    unique case (state_ff)
      TCC_ST_OFF:
        if (mode_ff != TCC_MODE_NONE)
          nxt_state = (role == TCC_ROLE_SINK) ? TCC_ST_UNATT_SNK : TCC_ST_UNATT_SRC;
      TCC_ST_UNATT_SRC:
        if (ra == 2'b11)
          nxt_state = TCC_ST_AUDIO;
        else if (^rd)
        begin
          nxt_state = TCC_ST_ATT_SRC;
          nxt_orientPos2 = rd[1];
        end
        else if (role == TCC_ROLE_DUAL && toggleCnt_ff == '0)
          nxt_state = TCC_ST_UNATT_SNK;
      TCC_ST_UNATT_SNK:
        if (vbus && (rp1 != TCC_LVL_NONE || rp2 != TCC_LVL_NONE))
        begin
          nxt_state = TCC_ST_ATT_SNK;
          nxt_orientPos2 = (rp2 != TCC_LVL_NONE);
          nxt_level = maxLevel(rp1, rp2);
        end
        else if (role == TCC_ROLE_DUAL && toggleCnt_ff == '0)
          nxt_state = TCC_ST_UNATT_SRC;
      TCC_ST_ATT_SRC:
        if (!(orientPos2_ff ? rd[1] : rd[0]))
          nxt_state = TCC_ST_UNATT_SRC;
      TCC_ST_AUDIO:
        if (ra != 2'b11)
          nxt_state = TCC_ST_UNATT_SRC;
      TCC_ST_ATT_SNK:
        if (!vbus)
        begin
          nxt_state = TCC_ST_UNATT_SNK;
          nxt_level = TCC_LVL_NONE;
        end
        else if ((orientPos2_ff ? rp2 : rp1) != TCC_LVL_NONE)
          nxt_level = orientPos2_ff ? rp2 : rp1;
      default:
        nxt_state = TCC_ST_OFF;
    endcase
    if (!en)
    begin
      nxt_state = TCC_ST_OFF;
      nxt_level = TCC_LVL_NONE;
    end
    if (nxt_state != state_ff)
      nxt_toggleCnt = TCC_TOGGLE_W'(TCC_TOGGLE_CYCLES);
    // Set wins over the host's clear; attach state is part of the readable registers
    nxt_intPend = en && busMode &&
                  (regChange || nxt_state != state_ff || nxt_level != level_ff || (intPend_ff && !intClear));
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_ff <= TCC_MODE_NONE;
      state_ff <= TCC_ST_OFF;
      toggleCnt_ff <= TCC_TOGGLE_W'(TCC_TOGGLE_CYCLES);
      orientPos2_ff <= 1'b0;
      level_ff <= TCC_LVL_NONE;
      intPend_ff <= 1'b0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      state_ff <= nxt_state;
      toggleCnt_ff <= nxt_toggleCnt;
      orientPos2_ff <= nxt_orientPos2;
      level_ff <= nxt_level;
      intPend_ff <= nxt_intPend;
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers, all registered
  // ---------------------------------------------------------------
  logic orientOeN_ff, nxt_orientOeN, srcOeN_ff, nxt_srcOeN, intOeN_ff, nxt_intOeN;
  logic sdaOeN_ff, nxt_sdaOeN, sclOeN_ff, nxt_sclOeN, busEn_ff, nxt_busEn;
  logic busSda_ff, nxt_busSda, busScl_ff, nxt_busScl, attached_ff, nxt_attached;
  logic pinLow_ff, sinkOn, isAttached;
  logic [6:0] addr_ff, nxt_addr;

  assign sinkOn = (state_ff == TCC_ST_ATT_SNK) && !busMode;
  assign isAttached = (state_ff == TCC_ST_ATT_SRC) || (state_ff == TCC_ST_ATT_SNK);
  always_comb
  begin
    // Released (high) is the idle level of every open-drain pin, and the disabled level
    nxt_orientOeN = !(isAttached && !orientPos2_ff);
    nxt_srcOeN = !(state_ff == TCC_ST_ATT_SRC);
    nxt_busEn = busMode;
    nxt_addr = (mode_ff == TCC_MODE_BUS_HIGH) ? TCC_ADDR_STRAP_HIGH :
               (mode_ff == TCC_MODE_BUS_LOW) ? TCC_ADDR_STRAP_LOW : TCC_ADDR_NONE;
    nxt_busSda = busMode ? sdaSync : 1'b1;
    nxt_busScl = busMode ? sclSync : 1'b1;
    nxt_attached = isAttached;
    if (busMode)
    begin
      nxt_intOeN = !intPend_ff;
      nxt_sdaOeN = !busSdaPullLow;
      nxt_sclOeN = !busSclHold;
    end
    else
    begin
      nxt_intOeN = !(state_ff == TCC_ST_AUDIO && mode_ff == TCC_MODE_GPIO);
      nxt_sdaOeN = !(sinkOn && level_ff >= TCC_LVL_MEDIUM);
      nxt_sclOeN = !(sinkOn && level_ff == TCC_LVL_HIGH);
    end
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      orientOeN_ff <= 1'b1;
      srcOeN_ff <= 1'b1;
      intOeN_ff <= 1'b1;
      sdaOeN_ff <= 1'b1;
      sclOeN_ff <= 1'b1;
      busEn_ff <= 1'b0;
      addr_ff <= TCC_ADDR_NONE;
      busSda_ff <= 1'b1;
      busScl_ff <= 1'b1;
      attached_ff <= 1'b0;
      pinLow_ff <= 1'b0;
    end
    else
    begin
      orientOeN_ff <= nxt_orientOeN;
      srcOeN_ff <= nxt_srcOeN;
      intOeN_ff <= nxt_intOeN;
      sdaOeN_ff <= nxt_sdaOeN;
      sclOeN_ff <= nxt_sclOeN;
      busEn_ff <= nxt_busEn;
      addr_ff <= nxt_addr;
      busSda_ff <= nxt_busSda;
      busScl_ff <= nxt_busScl;
      attached_ff <= nxt_attached;
      pinLow_ff <= 1'b0;
    end
  end

  assign orientOut = pinLow_ff;
  assign orientOeN = orientOeN_ff;
  assign sourceAttachOut = pinLow_ff;
  assign sourceAttachOeN = srcOeN_ff;
  assign sharedIntOut = pinLow_ff;
  assign sharedIntOeN = intOeN_ff;
  assign sdaOut = pinLow_ff;
  assign sdaOeN = sdaOeN_ff;
  assign sclOut = pinLow_ff;
  assign sclOeN = sclOeN_ff;
  assign busEnable = busEn_ff;
  assign busAddress = addr_ff;
  assign busSdaIn = busSda_ff;
  assign busSclIn = busScl_ff;
  assign attached = attached_ff;
  assign currentLevel = level_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence seqSrcAttached;
    state_ff == TCC_ST_ATT_SRC;
  endsequence

  chk_strap_high_addr: assert property (@(posedge clk) disable iff (!reset_n)
    mode_ff == TCC_MODE_BUS_HIGH |=> addr_ff == 7'h67 && busEn_ff)
    else $error("Bus address wrong for high strap");
  chk_strap_low_addr: assert property (@(posedge clk) disable iff (!reset_n)
    mode_ff == TCC_MODE_BUS_LOW |=> addr_ff == 7'h47 && busEn_ff)
    else $error("Bus address wrong for low strap");
  chk_orient_pin: assert property (@(posedge clk) disable iff (!reset_n)
    isAttached |=> orientOeN_ff == $past(orientPos2_ff))
    else $error("Orientation pin does not follow plug position");
  chk_int_raise: assert property (@(posedge clk) disable iff (!reset_n)
    (en && busMode && regChange) |=> ##1 !intOeN_ff)
    else $error("Interrupt not raised after register change");
  chk_audio_pin: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == TCC_ST_AUDIO && mode_ff == TCC_MODE_GPIO) |=> !intOeN_ff)
    else $error("Audio accessory not reported");
  chk_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    (sinkOn && level_ff == TCC_LVL_DEFAULT) |=> sdaOeN_ff)
    else $error("Flag A pulled low for default current");
  chk_flag_b: assert property (@(posedge clk) disable iff (!reset_n)
    (sinkOn && level_ff == TCC_LVL_HIGH) |=> !sclOeN_ff && !sdaOeN_ff)
    else $error("High current not shown on both flags");
  chk_src_attach: assert property (@(posedge clk) disable iff (!reset_n)
    seqSrcAttached ##1 seqSrcAttached |-> !srcOeN_ff)
    else $error("Source attach pin not pulled low");
  chk_disable_off: assert property (@(posedge clk) disable iff (!reset_n)
    !en [*3] |-> state_ff == TCC_ST_OFF && srcOeN_ff && orientOeN_ff && intOeN_ff)
    else $error("Pins or state active while disabled");
  chk_sink_power: assert property (@(posedge clk) disable iff (!reset_n)
    state_ff == TCC_ST_ATT_SNK |-> $past(vbus))
    else $error("Sink attached without bus power");
  chk_drp_toggle: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == TCC_ST_UNATT_SRC && role == TCC_ROLE_DUAL && en && ra != 2'b11 && !(^rd) && toggleCnt_ff == '0)
    |=> state_ff == TCC_ST_UNATT_SNK)
    else $error("Dual-role did not toggle to sink");
endmodule

`default_nettype wire

// *** tcc_cc_partner.sv ***
// Behavioural port partner as seen through the CC comparators and bus power sense
`timescale 1ns/100ps
`default_nettype none

module tcc_cc_partner
  import tcc_pkg::*;
(
  input wire logic [1:0] kind,
  input wire logic side,
  input wire logic [1:0] level,
  input wire logic power,
  output logic [1:0] ccRdDet,
  output logic [1:0] ccRaDet,
  output logic [1:0] cc1RpLevel,
  output logic [1:0] cc2RpLevel,
  output logic busPowerSense
);
  // ----------------------------------------
  // Terminations: 0 none, 1 sink, 2 source, 3 audio
  // ----------------------------------------
  // Inputs change only after a clock edge, so the terminations do too
  assign ccRdDet = (kind == 2'h1) ? (side ? 2'h2 : 2'h1) : 2'h0;
  assign ccRaDet = (kind == 2'h3) ? 2'h3 : 2'h0;
  assign cc1RpLevel = (kind == 2'h2 && !side) ? level : TCC_LVL_NONE;
  assign cc2RpLevel = (kind == 2'h2 && side) ? level : TCC_LVL_NONE;
  // A sink never sees bus power unless the source really supplies it
  assign busPowerSense = (kind == 2'h2) && power;
endmodule

`default_nettype wire

// *** tcc_cc_status_tb.sv ***
// Self-checking testbench for the configuration-channel status block
`timescale 1ns/100ps
`default_nettype none

`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin nErrors++; $display("BAD t=%0t got %h exp %h", $time, got, exp); end end

module tcc_cc_status_tb
  import tcc_pkg::*;
;
  logic clk, reset_n, enableN, strapHigh, strapLow, busPowerSense, regChange, intClear;
  logic [1:0] ccRdDet, ccRaDet, cc1RpLevel, cc2RpLevel, roleSelect, pKind, pLevel;
  logic sdaIn, sclIn, busSdaPullLow, busSclHold, hostSda, hostScl, pSide, pPower;
  logic orientOut, orientOeN, sourceAttachOut, sourceAttachOeN, sharedIntOut, sharedIntOeN;
  logic sdaOut, sdaOeN, sclOut, sclOeN, busEnable, busSdaIn, busSclIn, attached;
  logic [6:0] busAddress;
  logic [1:0] currentLevel;
  int nErrors = 0;
  int checks = 0;

  // Open-drain wires: host pull-up unless either party pulls low
  assign sdaIn = hostSda & sdaOeN;
  assign sclIn = hostScl & sclOeN;

  tcc_cc_partner i_tcc_cc_partner (.kind(pKind), .side(pSide), .level(pLevel), .power(pPower),
    .ccRdDet(ccRdDet), .ccRaDet(ccRaDet), .cc1RpLevel(cc1RpLevel), .cc2RpLevel(cc2RpLevel),
    .busPowerSense(busPowerSense));

  tcc_cc_status i_tcc_cc_status (.clk(clk), .reset_n(reset_n), .enableN(enableN), .strapHigh(strapHigh),
    .strapLow(strapLow), .busPowerSense(busPowerSense), .ccRdDet(ccRdDet), .ccRaDet(ccRaDet),
    .cc1RpLevel(cc1RpLevel), .cc2RpLevel(cc2RpLevel), .roleSelect(roleSelect), .regChange(regChange),
    .intClear(intClear), .sdaIn(sdaIn), .sclIn(sclIn), .busSdaPullLow(busSdaPullLow),
    .busSclHold(busSclHold), .orientOut(orientOut), .orientOeN(orientOeN),
    .sourceAttachOut(sourceAttachOut), .sourceAttachOeN(sourceAttachOeN), .sharedIntOut(sharedIntOut),
    .sharedIntOeN(sharedIntOeN), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .sclOut(sclOut), .sclOeN(sclOeN),
    .busEnable(busEnable), .busAddress(busAddress), .busSdaIn(busSdaIn), .busSclIn(busSclIn),
    .attached(attached), .currentLevel(currentLevel));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic complete_run();
    $display("Checks %0d, errors %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic enable_mode(input logic h, input logic l);
    enableN <= 1'b1;
    tick(6);
    strapHigh <= h;
    strapLow <= l;
    tick(4);
    enableN <= 1'b0;
    tick(8);
  endtask

  task automatic pulse(input logic chg, input logic clr);
    regChange <= chg;
    intClear <= clr;
    tick(1);
    regChange <= 1'b0;
    intClear <= 1'b0;
    tick(4);
  endtask

  // Dual role toggles every 2501 cycles, so an attach may take over 2501
  task automatic plug(input logic [1:0] k, input logic s, input logic [1:0] lv, input logic pw);
    int n = 0;
    pKind <= k;
    pSide <= s;
    pLevel <= lv;
    pPower <= pw;
    tick(1);
    while (n < 6000 && ((k == 2'h0) ? (attached !== 1'b0 || sharedIntOeN !== 1'b1)
                                    : (attached !== 1'b1 && sharedIntOeN !== 1'b0)))
    begin
      tick(1);
      n++;
    end
    tick(3);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_strap();
    enable_mode(1'b1, 1'b0);
    `CHECK(busEnable, 1'b1)
    `CHECK(busAddress, 7'h67)
    enable_mode(1'b0, 1'b1);
    `CHECK(busEnable, 1'b1)
    `CHECK(busAddress, 7'h47)
    enable_mode(1'b0, 1'b0);
    `CHECK(busEnable, 1'b0)
    `CHECK(busAddress, 7'h00)
    // Strap is latched at enable only, later moves are ignored
    strapHigh <= 1'b1;
    tick(6);
    `CHECK(busEnable, 1'b0)
    strapHigh <= 1'b0;
  endtask

  task automatic test_src_attach();
    plug(2'h1, 1'b0, 2'h0, 1'b0);
    `CHECK(attached, 1'b1)
    `CHECK(sourceAttachOeN, 1'b0)
    `CHECK(orientOeN, 1'b0)
    `CHECK({orientOut, sourceAttachOut, sharedIntOut, sdaOut, sclOut}, 5'h00)
    plug(2'h0, 1'b0, 2'h0, 1'b0);
    `CHECK(sourceAttachOeN, 1'b1)
    plug(2'h1, 1'b1, 2'h0, 1'b0);
    `CHECK(attached, 1'b1)
    `CHECK(orientOeN, 1'b1)
    plug(2'h0, 1'b0, 2'h0, 1'b0);
  endtask

  task automatic test_sink_levels();
    for (int lv = 1; lv <= 3; lv++)
    begin
      plug(2'h2, lv[0], lv[1:0], 1'b1);
      `CHECK(attached, 1'b1)
      `CHECK(currentLevel, lv[1:0])
      `CHECK(sdaOeN, (lv == 1))
      `CHECK(sclOeN, (lv != 3))
      `CHECK(sourceAttachOeN, 1'b1)
      `CHECK(orientOeN, lv[0])
      plug(2'h0, 1'b0, 2'h0, 1'b0);
    end
    plug(2'h2, 1'b0, 2'h1, 1'b0);
    `CHECK(attached, 1'b0)
    `CHECK(sdaOeN, 1'b1)
    plug(2'h0, 1'b0, 2'h0, 1'b0);
  endtask

  task automatic test_audio();
    pulse(1'b1, 1'b0);
    `CHECK(sharedIntOeN, 1'b1)
    plug(2'h3, 1'b0, 2'h0, 1'b0);
    `CHECK(sharedIntOeN, 1'b0)
    `CHECK(attached, 1'b0)
    plug(2'h0, 1'b0, 2'h0, 1'b0);
    `CHECK(sharedIntOeN, 1'b1)
  endtask

  task automatic test_bus_mode();
    roleSelect <= 2'h0;
    enable_mode(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    `CHECK(sharedIntOeN, 1'b1)
    pulse(1'b1, 1'b0);
    `CHECK(sharedIntOeN, 1'b0)
    pulse(1'b1, 1'b1);
    `CHECK(sharedIntOeN, 1'b0)
    pulse(1'b0, 1'b1);
    `CHECK(sharedIntOeN, 1'b1)
    busSdaPullLow <= 1'b1;
    busSclHold <= 1'b1;
    tick(3);
    `CHECK(sdaOeN, 1'b0)
    `CHECK(sclOeN, 1'b0)
    busSdaPullLow <= 1'b0;
    busSclHold <= 1'b0;
    hostSda <= 1'b0;
    tick(6);
    `CHECK(busSdaIn, 1'b0)
    `CHECK(busSclIn, 1'b1)
    hostSda <= 1'b1;
    hostScl <= 1'b0;
    tick(6);
    `CHECK(busSdaIn, 1'b1)
    `CHECK(busSclIn, 1'b0)
    hostScl <= 1'b1;
    plug(2'h1, 1'b0, 2'h0, 1'b0);
    `CHECK(sourceAttachOeN, 1'b0)
    // Sink-only role picked over the bus; the current flags stay with the bus engine
    roleSelect <= 2'h1;
    enable_mode(1'b0, 1'b1);
    pulse(1'b0, 1'b1);
    plug(2'h2, 1'b0, 2'h3, 1'b1);
    `CHECK(attached, 1'b1)
    `CHECK(currentLevel, TCC_LVL_HIGH)
    `CHECK(busAddress, 7'h47)
    `CHECK(sclOeN, 1'b1)
    `CHECK(sourceAttachOeN, 1'b1)
    `CHECK(orientOeN, 1'b0)
  endtask

  task automatic test_disable();
    enableN <= 1'b1;
    tick(8);
    `CHECK(attached, 1'b0)
    `CHECK(busEnable, 1'b0)
    `CHECK(sourceAttachOeN & orientOeN & sharedIntOeN & sdaOeN & sclOeN, 1'b1)
    pulse(1'b1, 1'b0);
    `CHECK(sharedIntOeN, 1'b1)
  endtask

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    tick(60000);
    nErrors++;
    $display("BAD t=%0t watchdog expired", $time);
    complete_run();
  end

  initial
  begin
    {reset_n, strapHigh, strapLow, regChange, intClear, busSdaPullLow, busSclHold} <= 7'h00;
    {enableN, hostSda, hostScl} <= 3'h7;
    {roleSelect, pKind, pLevel, pSide, pPower} <= 8'h00;
    tick(12);
    `CHECK(sourceAttachOeN & orientOeN & sharedIntOeN & busSdaIn, 1'b1)
    `CHECK({busEnable, busAddress, attached, currentLevel}, 11'h000)
    reset_n <= 1'b1;
    test_strap();
    test_src_attach();
    test_sink_levels();
    test_audio();
    test_bus_mode();
    test_disable();
    complete_run();
  end
endmodule

`default_nettype wire
